// ==== core/cst_cfg.svh ====
`ifndef CST_CFG_SVH
`define CST_CFG_SVH

// register byte offsets
`define CST_ADDR_CTRL         8'h00
`define CST_ADDR_SCALE        8'h04
`define CST_ADDR_STATUS       8'h08
`define CST_ADDR_TIMER        8'h0c

// control register fields and reset values
`define CST_CTRL_PER_PHASE    0
`define CST_CTRL_NBD_EN       1
`define CST_CTRL_TYPE2        2
`define CST_CTRL_TERM_LSB     4
`define CST_CTRL_MASK         8'h77
`define CST_CTRL_RESET        8'h03
`define CST_SCALE_RESET       8'h01

// status register fields
`define CST_ST_STATE_LSB      0
`define CST_ST_CHARGE_ON      3
`define CST_ST_OVP            4
`define CST_ST_TEMP           5
`define CST_ST_DIE            6
`define CST_ST_TIMEOUT        7
`define CST_ST_NOBAT          8
`define CST_ST_FLASH          9
`define CST_ST_PIN_A          10
`define CST_ST_PIN_B          11
`define CST_ST_TIMER_OFF      12

// bus answers
`define CST_RESP_OKAY         2'b00
`define CST_RESP_SLVERR       2'b10

// clock and prescaled tick
`define CST_CLK_PERIOD_NS     100
`define CST_TICK_MS           500
`define CST_TICK_CYCLES       (`CST_TICK_MS * 1000000 / `CST_CLK_PERIOD_NS)
`define CST_TICKS_PER_MIN     (60 * 1000 / `CST_TICK_MS)

// nominal phase timeouts
`define CST_TC_TIMEOUT_MIN    25
`define CST_CC_TIMEOUT_HR     1
`define CST_CV_TIMEOUT_HR     2
`define CST_ONE_TIMER_HR      3
`define CST_TC_TICKS          (`CST_TC_TIMEOUT_MIN * `CST_TICKS_PER_MIN)
`define CST_CC_TICKS          (`CST_CC_TIMEOUT_HR * 60 * `CST_TICKS_PER_MIN)
`define CST_CV_TICKS          (`CST_CV_TIMEOUT_HR * 60 * `CST_TICKS_PER_MIN)
`define CST_ONE_TICKS         (`CST_ONE_TIMER_HR * 60 * `CST_TICKS_PER_MIN)

// flashes after battery insertion, currents and regulation target
`define CST_POST_FLASHES      3'd5
`define CST_TRICKLE_PCT       7'd10
`define CST_FULL_PCT          7'd100
`define CST_TERM_DEFAULT_PCT  6'd10
`define CST_TERM_PCT_1        6'd5
`define CST_TERM_PCT_3        6'd20
`define CST_TERM_PCT_4        6'd30
`define CST_TERM_PCT_5        6'd40
`define CST_REG_MV            13'd4200

`endif

// ==== core/cst_pkg.sv ====
package cst_pkg;

	// charge sequencer states
	typedef enum logic [2:0] {
		CST_IDLE    = 3'b000,
		CST_TRICKLE = 3'b001,
		CST_FAST_CC = 3'b010,
		CST_CONST_V = 3'b011,
		CST_DONE    = 3'b100,
		CST_TIMEOUT = 3'b101,
		CST_NOBAT   = 3'b110
	} cst_state_t;

	// termination selection codes, 0 means the setting input is open
	typedef enum logic [2:0] {
		CST_TERM_OPEN = 3'b000,
		CST_TERM_5    = 3'b001,
		CST_TERM_10   = 3'b010,
		CST_TERM_20   = 3'b011,
		CST_TERM_30   = 3'b100,
		CST_TERM_40   = 3'b101
	} cst_term_t;

endpackage

// ==== core/cst_charger.sv ====
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cst_cfg.svh"
// What this block does
// - enter constant voltage at regulation level
// - stop at termination current into sleep
// - open termination setting means ten percent
// - termination selectable five to forty percent
// - sleep until below recharge, then recharge
// - low supply sleeps, recovery resumes charging
// - two outputs encode charging, complete, fault
// - status outputs are open-drain pull-downs
// - trickle timeout flashes first output 1 Hz
// - fault on overvoltage, temperature, timer, die
// - no battery flashes both at 1 Hz
// - five flashes after insertion, one in progress counting
// - without detection, treat output as battery
// - open thermistor means no battery
// - trickle timeout after twenty-five minutes
// - constant current restarts timer, one hour
// - per-phase: constant voltage restarts, two hours
// - single timer variant: three hours total
// - grounded timer input disables timeouts
// - timeouts scale linearly with timer setting
// - overvoltage suspends charging until it clears
// - overvoltage shows fault on second output only when type2 is set
// - charge only while enable high
// - below precondition level trickle at ten percent
// - precondition level reached moves to fast charge
module cst_charger #(
	parameter int TICK_CYCLES = `CST_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// comparator flags from the analog front end
	input  wire logic        supply_ok,
	input  wire logic        enable_in,
	input  wire logic        bat_below_min,
	input  wire logic        bat_at_reg,
	input  wire logic        bat_below_rch,
	input  wire logic        bat_over_ovp,
	input  wire logic        ts_hot,
	input  wire logic        ts_cold,
	input  wire logic        ts_open,
	input  wire logic        die_shutdown,
	input  wire logic        ichg_at_term,
	input  wire logic        battery_present,
	input  wire logic        timer_cap_grounded,
	// open-drain status pins
	input  wire logic        status_out_a_in,
	output logic             status_out_a_o,
	output logic             status_out_a_oe,
	input  wire logic        status_out_b_in,
	output logic             status_out_b_o,
	output logic             status_out_b_oe,
	// commands to the regulation loops
	output logic             charge_on,
	output logic             cv_mode,
	output logic [6:0]       current_pct,
	output logic [5:0]       termination_pct,
	output logic [12:0]      regulation_voltage_mv
);

	localparam int NSYNC = 15;

	// synchroniser stages and filtered values
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] sync3;
	logic [NSYNC-1:0] filt;
	logic [NSYNC-1:0] raw;

	logic             f_supply;
	logic             f_enable;
	logic             f_below_min;
	logic             f_at_reg;
	logic             f_below_rch;
	logic             f_ovp;
	logic             f_hot;
	logic             f_cold;
	logic             f_ts_open;
	logic             f_die;
	logic             f_at_term;
	logic             f_present;
	logic             f_cap_gnd;
	logic             f_pin_a;
	logic             f_pin_b;

	// software registers and bus state
	logic [7:0]       ctrl;
	logic [7:0]       scale;
	logic             aw_held;
	logic             w_held;
	logic [7:0]       aw_addr_q;
	logic [31:0]      w_data_q;
	logic [3:0]       w_strb_q;

	// sequencer, timer and flash state
	cst_pkg::cst_state_t state;
	cst_pkg::cst_state_t next_state;
	logic [22:0]      presc;
	logic             tick;
	logic [23:0]      timer_cnt;
	logic             timer_clear;
	logic             timer_off;
	logic             timed_out;
	logic             to_in_trickle;
	logic             flash_phase;
	logic [2:0]       post_flash;
	logic             nobat;
	logic             suspend;
	logic             temp_fault;
	logic             per_phase;

	// register address decode, shared by read and write paths
	function automatic logic addr_valid(input logic [7:0] a);
		addr_valid = (a == `CST_ADDR_CTRL) || (a == `CST_ADDR_SCALE) ||
			(a == `CST_ADDR_STATUS) || (a == `CST_ADDR_TIMER);
	endfunction

	// termination fraction of the fast charge current
	function automatic logic [5:0] term_of(input logic [2:0] sel);
		unique case (cst_pkg::cst_term_t'(sel))
			cst_pkg::CST_TERM_5:  term_of = `CST_TERM_PCT_1;
			cst_pkg::CST_TERM_20: term_of = `CST_TERM_PCT_3;
			cst_pkg::CST_TERM_30: term_of = `CST_TERM_PCT_4;
			cst_pkg::CST_TERM_40: term_of = `CST_TERM_PCT_5;
			default:              term_of = `CST_TERM_DEFAULT_PCT;
		endcase
	endfunction

	// timeout limit in ticks for the current phase, times the scale
	function automatic logic [23:0] limit_of(input cst_pkg::cst_state_t s,
			input logic pp, input logic [7:0] sc);
		logic [15:0] base;
		base = 16'(`CST_ONE_TICKS);
		if (s == cst_pkg::CST_TRICKLE) begin
			base = 16'(`CST_TC_TICKS);
		end else if (pp && s == cst_pkg::CST_FAST_CC) begin
			base = 16'(`CST_CC_TICKS);
		end else if (pp) begin
			base = 16'(`CST_CV_TICKS);
		end
		limit_of = base * sc;
	endfunction

	// pins cross in through three flops; a change counts when stages two and three agree
	assign raw = {supply_ok, enable_in, bat_below_min, bat_at_reg, bat_below_rch,
		bat_over_ovp, ts_hot, ts_cold, ts_open, die_shutdown, ichg_at_term,
		battery_present, timer_cap_grounded, status_out_a_in, status_out_b_in};
	assign {f_supply, f_enable, f_below_min, f_at_reg, f_below_rch, f_ovp, f_hot,
		f_cold, f_ts_open, f_die, f_at_term, f_present, f_cap_gnd, f_pin_a,
		f_pin_b} = filt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt  <= '0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
		end
	end

	// axi write channel: address and data may come in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CST_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held   <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_valid(aw_addr_q) ? `CST_RESP_OKAY : `CST_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable registers; status and timer words ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl  <= `CST_CTRL_RESET;
			scale <= `CST_SCALE_RESET;
		end else if (aw_held && w_held && w_strb_q[0]) begin
			if (aw_addr_q == `CST_ADDR_CTRL) begin
				ctrl <= w_data_q[7:0] & `CST_CTRL_MASK;
			end
			if (aw_addr_q == `CST_ADDR_SCALE) begin
				scale <= w_data_q[7:0];
			end
		end
	end

	// axi read channel, answer one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CST_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_valid(s_axi_araddr) ? `CST_RESP_OKAY : `CST_RESP_SLVERR;
			s_axi_rdata  <= 32'h0000_0000;
			unique case (s_axi_araddr)
				`CST_ADDR_CTRL:   s_axi_rdata[7:0] <= ctrl;
				`CST_ADDR_SCALE:  s_axi_rdata[7:0] <= scale;
				`CST_ADDR_STATUS: begin
					s_axi_rdata[`CST_ST_STATE_LSB +: 3] <= state;
					s_axi_rdata[`CST_ST_CHARGE_ON]      <= charge_on;
					s_axi_rdata[`CST_ST_OVP]            <= f_ovp;
					s_axi_rdata[`CST_ST_TEMP]           <= temp_fault;
					s_axi_rdata[`CST_ST_DIE]            <= f_die;
					s_axi_rdata[`CST_ST_TIMEOUT]        <= timed_out;
					s_axi_rdata[`CST_ST_NOBAT]          <= nobat;
					s_axi_rdata[`CST_ST_FLASH]          <= flash_phase;
					s_axi_rdata[`CST_ST_PIN_A]          <= f_pin_a;
					s_axi_rdata[`CST_ST_PIN_B]          <= f_pin_b;
					s_axi_rdata[`CST_ST_TIMER_OFF]      <= timer_off;
				end
				`CST_ADDR_TIMER:  s_axi_rdata[23:0] <= timer_cnt;
				default:          s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// derived conditions
	assign per_phase  = ctrl[`CST_CTRL_PER_PHASE];
	assign temp_fault = f_hot || f_cold;
	assign suspend    = f_ovp || temp_fault || f_die;
	assign nobat      = ctrl[`CST_CTRL_NBD_EN] && (!f_present || f_ts_open);
	assign timer_off  = f_cap_gnd || (scale == 8'h00);
	assign timed_out  = !timer_off && (timer_cnt >= limit_of(state, per_phase, scale));

	// one prescaled tick every half second drives every duration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= 23'h00_0000;
			tick  <= 1'b0;
		end else if (presc == 23'(TICK_CYCLES - 1)) begin
			presc <= 23'h00_0000;
			tick  <= 1'b1;
		end else begin
			presc <= presc + 23'h00_0001;
			tick  <= 1'b0;
		end
	end

	// charge phase sequencing; supply and enable override everything
	always_comb begin
		next_state = state;
		if (!f_supply || !f_enable) begin
			next_state = cst_pkg::CST_IDLE;
		end else if (nobat && state != cst_pkg::CST_TIMEOUT) begin
			next_state = cst_pkg::CST_NOBAT;
		end else if (!suspend) begin
			unique case (state)
				cst_pkg::CST_IDLE, cst_pkg::CST_NOBAT:
					next_state = f_below_min ? cst_pkg::CST_TRICKLE
						: cst_pkg::CST_FAST_CC;
				cst_pkg::CST_TRICKLE:
					if (timed_out) begin
						next_state = cst_pkg::CST_TIMEOUT;
					end else if (!f_below_min) begin
						next_state = cst_pkg::CST_FAST_CC;
					end
				cst_pkg::CST_FAST_CC:
					if (timed_out) begin
						next_state = cst_pkg::CST_TIMEOUT;
					end else if (f_at_reg) begin
						next_state = cst_pkg::CST_CONST_V;
					end
				cst_pkg::CST_CONST_V:
					if (timed_out) begin
						next_state = cst_pkg::CST_TIMEOUT;
					end else if (f_at_term) begin
						next_state = cst_pkg::CST_DONE;
					end
				cst_pkg::CST_DONE:
					if (f_below_rch) begin
						next_state = f_below_min ? cst_pkg::CST_TRICKLE
							: cst_pkg::CST_FAST_CC;
					end
				cst_pkg::CST_TIMEOUT:
					next_state = cst_pkg::CST_TIMEOUT;
				default:
					next_state = cst_pkg::CST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= cst_pkg::CST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// timer restarts on phase entry; the single-timer variant keeps counting into cv
	assign timer_clear = (next_state != state) &&
		!(next_state == cst_pkg::CST_CONST_V && !per_phase);

	// the count pauses while a suspend fault holds the charger off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_cnt <= 24'h00_0000;
		end else if (timer_clear) begin
			timer_cnt <= 24'h00_0000;
		end else if (tick && !suspend && !timer_off && timer_cnt != 24'hff_ffff) begin
			timer_cnt <= timer_cnt + 24'h00_0001;
		end
	end

	// remember whether the timeout struck during trickle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			to_in_trickle <= 1'b0;
		end else if (next_state == cst_pkg::CST_TIMEOUT && state != cst_pkg::CST_TIMEOUT) begin
			to_in_trickle <= (state == cst_pkg::CST_TRICKLE);
		end
	end

	// free 1 hz flash: half a period per tick gives equal on and off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_phase <= 1'b0;
		end else if (tick) begin
			flash_phase <= !flash_phase;
		end
	end

	// after a battery appears keep flashing until five lit phases have ended, counting one in progress
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			post_flash <= 3'd0;
		end else if (state == cst_pkg::CST_NOBAT && next_state != cst_pkg::CST_NOBAT) begin
			post_flash <= `CST_POST_FLASHES;
		end else if (next_state == cst_pkg::CST_IDLE || next_state == cst_pkg::CST_NOBAT) begin
			post_flash <= 3'd0;
		end else if (tick && flash_phase && post_flash != 3'd0) begin
			post_flash <= post_flash - 3'd1;
		end
	end

	// charger commands; the analog loops regulate to these
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			charge_on             <= 1'b0;
			cv_mode               <= 1'b0;
			current_pct           <= 7'd0;
			termination_pct       <= `CST_TERM_DEFAULT_PCT;
			regulation_voltage_mv <= `CST_REG_MV;
		end else begin
			charge_on <= !suspend && (next_state == cst_pkg::CST_TRICKLE ||
				next_state == cst_pkg::CST_FAST_CC || next_state == cst_pkg::CST_CONST_V);
			// a suspend fault freezes the phase but must not leave a current demand behind
			cv_mode <= !suspend && (next_state == cst_pkg::CST_CONST_V);
			if (suspend) begin
				current_pct <= 7'd0;
			end else if (next_state == cst_pkg::CST_TRICKLE) begin
				current_pct <= `CST_TRICKLE_PCT;
			end else if (next_state == cst_pkg::CST_FAST_CC || next_state == cst_pkg::CST_CONST_V) begin
				current_pct <= `CST_FULL_PCT;
			end else begin
				current_pct <= 7'd0;
			end
			termination_pct       <= term_of(ctrl[`CST_CTRL_TERM_LSB +: 3]);
			regulation_voltage_mv <= `CST_REG_MV;
		end
	end

	// open drain: the pin value is always low, the enable turns the led on
	assign status_out_a_o = 1'b0;
	assign status_out_b_o = 1'b0;

	// led pattern; flashing outranks fault, fault outranks charge states
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_out_a_oe <= 1'b0;
			status_out_b_oe <= 1'b0;
		end else if (state == cst_pkg::CST_IDLE) begin
			status_out_a_oe <= 1'b0;
			status_out_b_oe <= 1'b0;
		end else if (state == cst_pkg::CST_NOBAT || post_flash != 3'd0) begin
			status_out_a_oe <= flash_phase;
			status_out_b_oe <= flash_phase;
		end else if (suspend || state == cst_pkg::CST_TIMEOUT) begin
			status_out_a_oe <= (state == cst_pkg::CST_TIMEOUT) && to_in_trickle
				&& flash_phase;
			status_out_b_oe <= ctrl[`CST_CTRL_TYPE2];
		end else if (state == cst_pkg::CST_DONE) begin
			status_out_a_oe <= 1'b0;
			status_out_b_oe <= !ctrl[`CST_CTRL_TYPE2];
		end else begin
			status_out_a_oe <= 1'b1;
			status_out_b_oe <= 1'b0;
		end
	end

endmodule

// ==== tb/cst_partner.sv ====
`timescale 1ns/1ps
// battery cell and two indicators pulled up through leds
module cst_partner #(
	parameter int MIN_MV = 3000,
	parameter int RCH_MV = 4000,
	parameter int REG_MV = 4200,
	parameter int OVP_MV = 4400
) (
	// cell voltage chosen by the bench
	input  wire logic [12:0] bat_mv,
	// indicator drive from the charger
	input  wire logic        status_out_a_oe,
	input  wire logic        status_out_b_oe,
	// comparator results and pin levels
	output logic             bat_below_min,
	output logic             bat_at_reg,
	output logic             bat_below_rch,
	output logic             bat_over_ovp,
	output logic             status_out_a_in,
	output logic             status_out_b_in
);
	// ideal comparators, hysteresis is left to the analog side
	assign bat_below_min = bat_mv < MIN_MV;
	assign bat_at_reg    = bat_mv >= REG_MV;
	assign bat_below_rch = bat_mv < RCH_MV;
	assign bat_over_ovp  = bat_mv > OVP_MV;
	// released pins float up through the led and its resistor
	assign status_out_a_in = !status_out_a_oe;
	assign status_out_b_in = !status_out_b_oe;
endmodule

// ==== tb/cst_monitor.sv ====
`timescale 1ns/1ps
module cst_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// flags in
	input wire logic        supply_ok,
	input wire logic        enable_in,
	input wire logic        bat_over_ovp,
	input wire logic        die_shutdown,
	// pins and loop commands
	input wire logic        status_out_a_o,
	input wire logic        status_out_b_o,
	input wire logic        status_out_a_oe,
	input wire logic        status_out_b_oe,
	input wire logic        charge_on,
	input wire logic        cv_mode,
	input wire logic [6:0]  current_pct,
	input wire logic [5:0]  termination_pct,
	input wire logic [12:0] regulation_voltage_mv
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// eight cycles covers the three-flop filter plus state and output registers
	sequence s_supply_lost; !supply_ok [*8]; endsequence
	sequence s_disabled; !enable_in [*8]; endsequence
	sequence s_ovp_held; bat_over_ovp [*8]; endsequence
	sequence s_die_hot; die_shutdown [*8]; endsequence

	a_pins_drain: assert property (!status_out_a_o && !status_out_b_o)
		else $error("status pin drives high");
	a_reg_target: assert property (regulation_voltage_mv == 13'h1068)
		else $error("regulation target wrong");
	a_cv_full: assert property (cv_mode |-> charge_on && current_pct == 7'h64)
		else $error("cv mode without full current");
	a_off_zero: assert property (!charge_on |-> current_pct == 7'h00)
		else $error("current requested while off");
	a_term_set: assert property (termination_pct inside {6'h05, 6'h0a, 6'h14, 6'h1e, 6'h28})
		else $error("termination level out of set");
	a_supply_sleep: assert property (s_supply_lost |-> !charge_on)
		else $error("charging on low supply");
	a_enable_halt: assert property (s_disabled |-> !charge_on && !status_out_a_oe && !status_out_b_oe)
		else $error("active while disabled");
	a_ovp_stop: assert property (s_ovp_held |-> !charge_on)
		else $error("charging in overvoltage");
	a_die_stop: assert property (s_die_hot |-> !charge_on)
		else $error("charging in thermal shutdown");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule

bind cst_charger cst_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.supply_ok, .enable_in, .bat_over_ovp, .die_shutdown, .status_out_a_o, .status_out_b_o,
	.status_out_a_oe, .status_out_b_oe, .charge_on, .cv_mode, .current_pct, .termination_pct,
	.regulation_voltage_mv);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "cst_cfg.svh"
module tb;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic supply_ok = 1'b1, enable_in = 1'b0, ts_hot = 1'b0, ts_cold = 1'b0, ts_open = 1'b0;
	logic die_shutdown = 1'b0, ichg_at_term = 1'b0, battery_present = 1'b1;
	logic timer_cap_grounded = 1'b0;
	logic [12:0] bat_mv = 13'h0af0;
	logic bat_below_min, bat_at_reg, bat_below_rch, bat_over_ovp;
	logic status_out_a_in, status_out_b_in, status_out_a_oe, status_out_b_oe;
	logic charge_on, cv_mode;
	logic [6:0] current_pct;
	logic [5:0] termination_pct;
	logic [5:0] term_exp [6] = '{6'h0a, 6'h05, 6'h0a, 6'h14, 6'h1e, 6'h28};
	logic [31:0] d;
	logic [1:0] r;
	int err_total = 0, num_checks = 0, cycles = 0;

	// short tick keeps the trickle timeouts within the run
	cst_charger #(.TICK_CYCLES(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_ok,
		.enable_in, .bat_below_min, .bat_at_reg, .bat_below_rch, .bat_over_ovp, .ts_hot, .ts_cold,
		.ts_open, .die_shutdown, .ichg_at_term, .battery_present, .timer_cap_grounded,
		.status_out_a_in, .status_out_a_o(), .status_out_a_oe, .status_out_b_in,
		.status_out_b_o(), .status_out_b_oe, .charge_on, .cv_mode, .current_pct,
		.termination_pct, .regulation_voltage_mv());
	cst_partner u_cell (.bat_mv, .status_out_a_oe, .status_out_b_oe, .bat_below_min,
		.bat_at_reg, .bat_below_rch, .bat_over_ovp, .status_out_a_in, .status_out_b_in);

	// 10 MHz clock
	always #50 aclk = ~aclk;

	// hang guard, the longest wait is the doubled trickle timeout
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// both channels offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
		logic ap, wp;
		ap = 1'b1;
		wp = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && s_axi_awready) begin
				ap = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (wp && s_axi_wready) begin
				wp = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		cmp(32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		cmp(s_axi_rdata & m, e);
		cmp(32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// counts lit cycles over five one-hertz periods of the shortened tick
	task automatic flash(input int ea, input int eb);
		int ca, cb;
		ca = 0;
		cb = 0;
		repeat (20) begin
			@(posedge aclk);
			ca += int'(status_out_a_oe);
			cb += int'(status_out_b_oe);
		end
		cmp(32'(ca), 32'(ea));
		cmp(32'(cb), 32'(eb));
	endtask

	task automatic state(input logic on, input logic [6:0] pct, input logic a, input logic b);
		wt(12);
		cmp(32'(charge_on), 32'(on));
		cmp(32'(current_pct), 32'(pct));
		cmp(32'({status_out_a_oe, status_out_b_oe}), 32'({a, b}));
	endtask

	initial begin
		wt(8);
		aresetn <= 1'b1;
		wt(12);
		rd(`CST_ADDR_CTRL, 32'hff, 32'h03, `CST_RESP_OKAY);
		rd(`CST_ADDR_SCALE, 32'hff, 32'h01, `CST_RESP_OKAY);
		rd(8'h10, 32'hffffffff, 32'h0, `CST_RESP_SLVERR);
		wr(8'h10, 32'h0, `CST_RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			wr(`CST_ADDR_CTRL, {25'h0, i[2:0], 4'h3}, `CST_RESP_OKAY);
			wt(3);
			cmp(32'(termination_pct), 32'(term_exp[i]));
		end
		wr(`CST_ADDR_CTRL, 32'h03, `CST_RESP_OKAY);
		$display("registers done");
		enable_in <= 1'b1;
		state(1'b1, 7'h0a, 1'b1, 1'b0);
		bat_mv <= 13'h0e10;
		state(1'b1, 7'h64, 1'b1, 1'b0);
		bat_mv <= 13'h1068;
		wt(12);
		cmp(32'(cv_mode), 32'h1);
		ichg_at_term <= 1'b1;
		state(1'b0, 7'h00, 1'b0, 1'b1);
		ichg_at_term <= 1'b0;
		wt(20);
		cmp(32'(charge_on), 32'h0);
		bat_mv <= 13'h0f3c;
		state(1'b1, 7'h64, 1'b1, 1'b0);
		$display("charge cycle done");
		bat_mv <= 13'h1194;
		state(1'b0, 7'h00, 1'b0, 1'b0);
		wr(`CST_ADDR_CTRL, 32'h07, `CST_RESP_OKAY);
		state(1'b0, 7'h00, 1'b0, 1'b1);
		wr(`CST_ADDR_CTRL, 32'h03, `CST_RESP_OKAY);
		bat_mv <= 13'h1004;
		state(1'b1, 7'h64, 1'b1, 1'b0);
		die_shutdown <= 1'b1;
		state(1'b0, 7'h00, 1'b0, 1'b0);
		die_shutdown <= 1'b0;
		ts_hot <= 1'b1;
		state(1'b0, 7'h00, 1'b0, 1'b0);
		ts_hot <= 1'b0;
		$display("faults done");
		ts_open <= 1'b1;
		wt(12);
		flash(10, 10);
		ts_open <= 1'b0;
		battery_present <= 1'b0;
		wt(12);
		flash(10, 10);
		battery_present <= 1'b1;
		bat_mv <= 13'h0af0;
		wt(42);
		flash(20, 0);
		wr(`CST_ADDR_CTRL, 32'h01, `CST_RESP_OKAY);
		battery_present <= 1'b0;
		wt(12);
		flash(20, 0);
		battery_present <= 1'b1;
		wr(`CST_ADDR_CTRL, 32'h03, `CST_RESP_OKAY);
		timer_cap_grounded <= 1'b1;
		wt(12);
		rd(`CST_ADDR_STATUS, 32'h1000, 32'h1000, `CST_RESP_OKAY);
		timer_cap_grounded <= 1'b0;
		$display("indication done");
		enable_in <= 1'b0;
		wt(12);
		enable_in <= 1'b1;
		wt(5900);
		cmp(32'(charge_on), 32'h1);
		wt(200);
		cmp(32'(charge_on), 32'h0);
		flash(10, 0);
		supply_ok <= 1'b0;
		wr(`CST_ADDR_SCALE, 32'h02, `CST_RESP_OKAY);
		supply_ok <= 1'b1;
		wt(11900);
		cmp(32'(charge_on), 32'h1);
		wt(200);
		cmp(32'(charge_on), 32'h0);
		$display("timeouts done");
		end_sim();
	end
endmodule
